// file: rtl/btt_consts.vh
// register offsets, field positions and reset values for the bank trim / timestamp block
`ifndef BTT_CONSTS_VH
`define BTT_CONSTS_VH
`define BTT_ADDR_W 12
`define BTT_OFF_B3_ZERO 12'h132
`define BTT_OFF_B3_M90 12'h133
`define BTT_OFF_B4_ZERO 12'h142
`define BTT_OFF_B4_M90 12'h143
`define BTT_OFF_B5_ZERO 12'h152
`define BTT_OFF_B5_M90 12'h153
`define BTT_OFF_LSB_CTRL 12'h160
`define BTT_OFF_CFG 12'h170
`define BTT_LSB_CTRL_RST 8'h00
`define BTT_CFG_RST 8'h00
`define BTT_TS_EN_BIT 0
`define BTT_CFG_PHASE_BIT 0
`define BTT_CFG_CALST_BIT 1
`define BTT_CFG_TSRX_BIT 2
`define BTT_ILA_CS_VALUE 2'h0
`define BTT_TRIM_DEFAULT 8'h80
`endif

// file: rtl/btt_delay_line.v
// fixed-latency delay line for the timestamp marker
`timescale 1ns/1ps
`default_nettype none
module btt_delay_line #(
    parameter DEPTH = 4
) (
    input wire clk_sys_in,
    input wire rst_n_in,
    input wire d_in,
    output wire q_out
);
    reg [DEPTH-1:0] pipe_r;
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pipe_r <= {DEPTH{1'b0}};
        end else begin
            pipe_r <= {pipe_r[DEPTH-2:0], d_in};
        end
    end
    assign q_out = pipe_r[DEPTH-1];
endmodule
`default_nettype wire

// file: rtl/btt_top.v
// bank sampling-time trim registers and timestamp-on-lsb sample path
// Function
// - banks 3-5 each have an 8-bit RW trim used in zero-degree phase.
// - banks 3-5 each have a second 8-bit RW trim for minus-90 phase.
// - trims load factory values at reset; writes replace and take effect.
// - timestamp enable bit 0 replaces every sample lsb with the timestamp.
// - timestamp wins over calibration-state indication on the lsb.
// - timestamp is delayed by the same latency as the samples.
// - lane alignment control-bit count is always reported as zero.
//
// Local design decision: the strobed register port.
`include "btt_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module btt_top #(
    parameter NUM_BANKS = 3,
    parameter SAMPLE_W = 8,
    parameter LATENCY = 4,
    parameter [8*NUM_BANKS-1:0] FACTORY_ZERO = {3{`BTT_TRIM_DEFAULT}},
    parameter [8*NUM_BANKS-1:0] FACTORY_M90 = {3{`BTT_TRIM_DEFAULT}}
) (
    input wire clk_sys_in,
    input wire rst_n_in,
    input wire [`BTT_ADDR_W-1:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [7:0] rdata_out,
    input wire [SAMPLE_W-1:0] sample_in,
    input wire timestamp_in,
    input wire cal_state_in,
    output reg [SAMPLE_W-1:0] sample_out,
    output reg [8*NUM_BANKS-1:0] bank_trim_out,
    output reg timestamp_receiver_enable_out,
    output reg [1:0] ila_cs_out
);
    reg [7:0] trim_zero_r [0:NUM_BANKS-1];
    reg [7:0] trim_m90_r [0:NUM_BANKS-1];
    reg [7:0] sample_lsb_control_r;
    reg [7:0] cfg_r;
    reg [7:0] rdata_nxt;
    reg [SAMPLE_W-1:0] samp_pipe_r [0:LATENCY-1];
    reg [SAMPLE_W-1:0] sample_nxt;
    reg [8*NUM_BANKS-1:0] trim_nxt;
    reg cal_pipe_r [0:LATENCY-1];
    wire ts_delayed;
    wire ts_en;
    wire cal_en;
    integer i;
    integer j;
    integer k;

    assign ts_en = sample_lsb_control_r[`BTT_TS_EN_BIT];
    assign cal_en = cfg_r[`BTT_CFG_CALST_BIT];

    // per-bank trim storage; offsets step by 0x10 per bank from bank 3
    genvar g;
    generate
        for (g = 0; g < NUM_BANKS; g = g + 1) begin : g_bank
            wire [`BTT_ADDR_W-1:0] off_zero;
            wire [`BTT_ADDR_W-1:0] off_m90;
            // sums are formed at 32 bits and cut to the address width on purpose
            wire [31:0] off_zero_w;
            wire [31:0] off_m90_w;
            assign off_zero_w = `BTT_OFF_B3_ZERO + g * 16;
            assign off_m90_w = `BTT_OFF_B3_M90 + g * 16;
            assign off_zero = off_zero_w[`BTT_ADDR_W-1:0];
            assign off_m90 = off_m90_w[`BTT_ADDR_W-1:0];
            always @(posedge clk_sys_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    trim_zero_r[g] <= FACTORY_ZERO[8*g +: 8];
                    trim_m90_r[g] <= FACTORY_M90[8*g +: 8];
                end else if (wr_in) begin
                    if (addr_in == off_zero) begin
                        trim_zero_r[g] <= wdata_in;
                    end
                    if (addr_in == off_m90) begin
                        trim_m90_r[g] <= wdata_in;
                    end
                end
            end
        end
    endgenerate

    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sample_lsb_control_r <= `BTT_LSB_CTRL_RST;
            cfg_r <= `BTT_CFG_RST;
        end else if (wr_in) begin
            if (addr_in == `BTT_OFF_LSB_CTRL) begin
                sample_lsb_control_r <= wdata_in;
            end
            if (addr_in == `BTT_OFF_CFG) begin
                cfg_r <= wdata_in;
            end
        end
    end

    always @* begin
        rdata_nxt = 8'h00;
        for (i = 0; i < NUM_BANKS; i = i + 1) begin
            if (addr_in == `BTT_OFF_B3_ZERO + i * 16) begin
                rdata_nxt = trim_zero_r[i];
            end
            if (addr_in == `BTT_OFF_B3_M90 + i * 16) begin
                rdata_nxt = trim_m90_r[i];
            end
        end
        if (addr_in == `BTT_OFF_LSB_CTRL) begin
            rdata_nxt = sample_lsb_control_r;
        end
        if (addr_in == `BTT_OFF_CFG) begin
            rdata_nxt = cfg_r;
        end
    end

    // read data valid only in the cycle after the strobe, zero otherwise
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= rd_in ? rdata_nxt : 8'h00;
        end
    end

    // active trim follows the selected clock phase
    always @* begin
        trim_nxt = {8*NUM_BANKS{1'b0}};
        for (j = 0; j < NUM_BANKS; j = j + 1) begin
            if (cfg_r[`BTT_CFG_PHASE_BIT]) begin
                trim_nxt[8*j +: 8] = trim_m90_r[j];
            end else begin
                trim_nxt[8*j +: 8] = trim_zero_r[j];
            end
        end
    end

    // sample path pipeline models the converter latency
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (k = 0; k < LATENCY; k = k + 1) begin
                samp_pipe_r[k] <= {SAMPLE_W{1'b0}};
                cal_pipe_r[k] <= 1'b0;
            end
        end else begin
            samp_pipe_r[0] <= sample_in;
            cal_pipe_r[0] <= cal_state_in;
            for (k = 1; k < LATENCY; k = k + 1) begin
                samp_pipe_r[k] <= samp_pipe_r[k-1];
                cal_pipe_r[k] <= cal_pipe_r[k-1];
            end
        end
    end

    // same depth as the sample pipe so marks line up with their sample
    btt_delay_line #(
        .DEPTH(LATENCY)
    ) u_ts_delay (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .d_in(timestamp_in),
        .q_out(ts_delayed)
    );

    always @* begin
        sample_nxt = samp_pipe_r[LATENCY-1];
        if (ts_en) begin
            sample_nxt[0] = ts_delayed;
        end else if (cal_en) begin
            sample_nxt[0] = cal_pipe_r[LATENCY-1];
        end
    end

    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sample_out <= {SAMPLE_W{1'b0}};
            bank_trim_out <= {8*NUM_BANKS{1'b0}};
            timestamp_receiver_enable_out <= 1'b0;
            ila_cs_out <= `BTT_ILA_CS_VALUE;
        end else begin
            sample_out <= sample_nxt;
            bank_trim_out <= trim_nxt;
            // software owns this bit; timestamps need it set too
            timestamp_receiver_enable_out <= cfg_r[`BTT_CFG_TSRX_BIT];
            ila_cs_out <= `BTT_ILA_CS_VALUE;
        end
    end
endmodule
`default_nettype wire

// file: tb/btt_top_asserts.sv
// port-level checker for the trim bank and timestamp lsb block
`timescale 1ns/1ps
`default_nettype none
`include "btt_consts.vh"
module btt_checker #(parameter NUM_BANKS = 3, parameter SAMPLE_W = 8, parameter LATENCY = 4) (
    input wire clk_sys_in,
    input wire rst_n_in,
    input wire [`BTT_ADDR_W-1:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [7:0] rdata_out,
    input wire [SAMPLE_W-1:0] sample_in,
    input wire timestamp_in,
    input wire cal_state_in,
    input wire [SAMPLE_W-1:0] sample_out,
    input wire [8*NUM_BANKS-1:0] bank_trim_out,
    input wire timestamp_receiver_enable_out,
    input wire [1:0] ila_cs_out
);
    reg ts_m, cal_m, ph_m, rx_m;
    reg [2:0] q_r;
    wire lsb_wr = wr_in && addr_in == `BTT_OFF_LSB_CTRL;
    wire cfg_wr = wr_in && addr_in == `BTT_OFF_CFG;
    // q_r counts quiet cycles so lsb checks skip the settling window
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            {ts_m, cal_m, ph_m, rx_m, q_r} <= 7'h00;
        end else begin
            if (lsb_wr) ts_m <= wdata_in[0];
            if (cfg_wr) {rx_m, cal_m, ph_m} <= wdata_in[2:0];
            q_r <= (lsb_wr || cfg_wr) ? 3'h0 : ((q_r == 3'h7) ? q_r : q_r + 3'h1);
        end
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    property p_ila; ila_cs_out == `BTT_ILA_CS_VALUE; endproperty
    property p_up; sample_out[SAMPLE_W-1:1] == $past(sample_in[SAMPLE_W-1:1], LATENCY+1);
    endproperty
    property p_ts; q_r == 3'h7 && ts_m |-> sample_out[0] == $past(timestamp_in, LATENCY+1);
    endproperty
    property p_own; q_r == 3'h7 && !ts_m && !cal_m |-> sample_out[0] == $past(sample_in[0], LATENCY+1);
    endproperty
    property p_rx; q_r > 3'h2 |-> timestamp_receiver_enable_out == rx_m; endproperty
    property p_tr0; wr_in && addr_in == `BTT_OFF_B3_ZERO && !ph_m |=> ##1 bank_trim_out[7:0] == $past(wdata_in, 2);
    endproperty
    property p_tr9; wr_in && addr_in == `BTT_OFF_B5_M90 && ph_m |=> ##1 bank_trim_out[23:16] == $past(wdata_in, 2);
    endproperty
    property p_rd; !$past(rd_in) |-> rdata_out == 8'h00; endproperty
    a_ila: assert property (p_ila) else $error("ila count nonzero");
    a_up: assert property (p_up) else $error("sample upper bits");
    a_ts: assert property (p_ts) else $error("timestamp lsb");
    a_own: assert property (p_own) else $error("own lsb");
    a_rx: assert property (p_rx) else $error("ts receiver enable");
    a_tr0: assert property (p_tr0) else $error("zero phase trim");
    a_tr9: assert property (p_tr9) else $error("minus90 trim");
    a_rd: assert property (p_rd) else $error("rdata not idle");
    c_ts: cover property (q_r == 3'h7 && ts_m && cal_m);
    c_rd: cover property (rd_in);
    c_ph: cover property (wr_in && ph_m);
endmodule
bind btt_top btt_checker #(.NUM_BANKS(NUM_BANKS), .SAMPLE_W(SAMPLE_W), .LATENCY(LATENCY)) i_chk (.*);
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the trim bank and timestamp lsb block
`timescale 1ns/1ps
`default_nettype none
`include "btt_consts.vh"
module tb;
    localparam int L = 4;
    logic clk_sys_in = 0, rst_n_in = 0, wr_in = 0, rd_in = 0, timestamp_in = 0, cal_state_in = 0;
    logic [11:0] addr_in = 0;
    logic [7:0] wdata_in = 0, rdata_out, sample_in = 0, sample_out, cnt = 0, e;
    logic [23:0] bank_trim_out;
    logic timestamp_receiver_enable_out;
    logic [1:0] ila_cs_out;
    int num_errors = 0, n_checks = 0;
    always #2.5 clk_sys_in = ~clk_sys_in;
    btt_top #(.LATENCY(L)) i_dut (.*);
    // ts and cal taken from the same count so each sample's lsb sources are known
    always @(posedge clk_sys_in) if (rst_n_in) begin
        cnt <= cnt + 8'h01;
        {sample_in, timestamp_in, cal_state_in} <= {cnt, cnt[3], cnt[1]};
    end
    task chk(input string n, input [23:0] seen, input [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s exp %h got %h", n, exp, seen);
        end
    endtask
    task wr(input [11:0] a, input [7:0] d);
        @(posedge clk_sys_in) {wr_in, addr_in, wdata_in} <= {1'b1, a, d};
        @(posedge clk_sys_in) wr_in <= 1'b0;
    endtask
    task rd(input [11:0] a, input [7:0] exp);
        @(posedge clk_sys_in) {rd_in, addr_in} <= {1'b1, a};
        @(posedge clk_sys_in) rd_in <= 1'b0;
        @(negedge clk_sys_in) chk("rdata", rdata_out, exp);
    endtask
    function automatic [11:0] off(int i);
        return `BTT_OFF_B3_ZERO + 12'(i / 2 * 16 + i % 2);
    endfunction
    task t_reset;
        for (int i = 0; i < 6; i++) rd(off(i), `BTT_TRIM_DEFAULT);
        rd(`BTT_OFF_LSB_CTRL, `BTT_LSB_CTRL_RST);
        rd(12'h161, 8'h00);
        chk("trim_out", bank_trim_out, {3{`BTT_TRIM_DEFAULT}});
    endtask
    task t_trims;
        for (int i = 0; i < 6; i++) wr(off(i), 8'(8'h11 * (i + 1)));
        wr(`BTT_OFF_LSB_CTRL, 8'hA4);
        for (int i = 0; i < 6; i++) rd(off(i), 8'(8'h11 * (i + 1)));
        rd(`BTT_OFF_LSB_CTRL, 8'hA4);
        chk("trim_out", bank_trim_out, 24'h553311);
        wr(`BTT_OFF_CFG, 8'h01);
        wr(`BTT_OFF_B5_M90, 8'h77);
        repeat (2) @(posedge clk_sys_in);
        chk("trim_out", bank_trim_out, 24'h774422);
    endtask
    // sel picks which bit of the delayed count should land on the lsb
    task t_lsb(input [7:0] ctrl, input [7:0] cfg, input int sel);
        wr(`BTT_OFF_LSB_CTRL, ctrl);
        wr(`BTT_OFF_CFG, cfg);
        repeat (8) @(posedge clk_sys_in);
        chk("ts_rx_en", timestamp_receiver_enable_out, cfg[2]);
        repeat (16) begin
            @(negedge clk_sys_in) e = sample_in - 8'(L + 1);
            chk("sample", sample_out, {e[7:1], e[sel]});
        end
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        t_reset;
        t_trims;
        t_lsb(8'h00, 8'h00, 0);
        t_lsb(8'h00, 8'h02, 1);
        t_lsb(8'h01, 8'h06, 3);
        t_lsb(8'h01, 8'h00, 3);
        report_and_stop;
    end
    initial begin
        #20000;
        num_errors++;
        report_and_stop;
    end
endmodule
`default_nettype wire
